/* asc_config.sv */
// Behaviour
// - Only register 2 bit 0 and register 5 bits 6,7 are fixed; rest adapter-defined.
// - Channel reset returns every configuration field except the extension array to its default.
// - Read-only two-byte identifier, low byte register 0, high byte register 1.
// - Identifier reads all zeros while the adapter is not ready.
// - Card enable bit 0 of register 2 gates the channel interface outside setup.
// - Card enable resets to 0.
// - Raising the exception line clears check bit 7 of register 5, except address parity.
// - Master writing 1 to the check bit releases the exception line.
// - Check bit written 0 during setup does not assert the exception line.
// - I/O address select field chooses among eight decode ranges.
// - Four-bit memory select gives A16..A13 of ROM/RAM start in C0000-DFFFF.
// - Four-bit read/write arbitration level field.
// - Auto-increment, default off, advances index on each register 3 or 4 access.
// - Exception reporting select, default off, chooses synchronous reporting.
// - Read-only status indicator bit 6 of register 5 resets to 1.
// - Indicator and check bit both 0 make registers 6,7 return check status.
// - Status indicator is implemented together with the check bit.
// - Parity enable resets disabled; disabled means no parity lines, no checking.
// - Parity enable is two bits, data and address separately.
// - Six-bit assignment field supplies I/O address bits 15..10.
// - Registers decode only under setup select, using address bits 2..0.
// - Drivers enable during setup reads even with card enable at 0.
module asc_config #(
	parameter logic [15:0] ADAPTER_ID = 16'h5a3c, // Arbitrary value
	parameter int          EXT_DEPTH  = 16
) (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 channel_reset_line,
	input  wire logic                 card_setup_select,
	input  wire logic                 setup_write,
	input  wire logic                 setup_strobe,
	input  wire logic [2:0]           setup_addr,
	input  wire logic [7:0]           setup_wdata,
	output logic      [7:0]           setup_rdata,
	output logic                      setup_drive_en,
	input  wire logic                 adapter_ready,
	input  wire logic                 exception_event,
	input  wire logic                 exception_is_addr_parity,
	input  wire logic                 exception_is_sync_class,
	input  wire logic [15:0]          check_status,
	output logic                      channel_exception_line,
	output logic                      exception_sync_mode,
	output logic                      interface_enable,
	output logic                      data_parity_enable_line,
	output logic                      address_parity_enable_line,
	output logic                      data_parity_check_en,
	output logic                      address_parity_check_en,
	output logic      [2:0]           io_select,
	output logic      [3:0]           rom_select,
	output logic      [19:0]          rom_base,
	output logic      [3:0]           arb_level,
	output logic      [5:0]           io_assign,
	output logic      [15:0]          ext_index
);
	import asc_pkg::*;

	logic [7:0]  opt1;
	logic [7:0]  opt2;
	logic [7:0]  opt3;
	logic [5:0]  opt4;
	logic        chan_check;
	logic        status_ind;
	logic [15:0] index;
	logic [7:0]  ext_mem [EXT_DEPTH];

	logic        sel_s;
	logic        wr_s;
	logic        stb_s;
	logic        channel_reset_line_s;
	logic        stb_rise;
	logic        clear_all;

	// Extension array is indexed by low index bits, so depth must be a power of two
	if (EXT_DEPTH < 2 || EXT_DEPTH > 65536 || (EXT_DEPTH & (EXT_DEPTH - 1)) != 0) begin : g_depth_bad
		$error("EXT_DEPTH must be a power of two from 2 to 65536");
	end

	asc_sync #(
		.WIDTH(4)
	) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({card_setup_select, setup_write, setup_strobe, channel_reset_line}),
		.q      ({sel_s, wr_s, stb_s, channel_reset_line_s})
	);

	asc_strobe u_strobe (
		.clk    (clk),
		.resetn (resetn),
		.level  (stb_s),
		.rise   (stb_rise)
	);

	assign clear_all = !resetn || channel_reset_line_s;

	// Access decode
	wire access    = stb_rise & sel_s;
	wire wr_access = access & wr_s;
	wire hit_opt1  = setup_addr == REG_OPT1;
	wire hit_opt2  = setup_addr == REG_OPT2;
	wire hit_opt3  = setup_addr == REG_OPT3;
	wire hit_opt4  = setup_addr == REG_OPT4;
	wire hit_sub_l = setup_addr == REG_SUB_LOW;
	wire hit_sub_h = setup_addr == REG_SUB_HIGH;
	wire ext_sel   = index != INDEX_RESET;
	wire [$clog2(EXT_DEPTH)-1:0] ext_addr = index[$clog2(EXT_DEPTH)-1:0];
	wire ext_wr    = wr_access & ext_sel & (hit_opt2 | hit_opt3);
	wire wr_opt1   = wr_access & hit_opt1;
	wire wr_opt2   = wr_access & hit_opt2 & !ext_sel;
	wire wr_opt3   = wr_access & hit_opt3 & !ext_sel;
	wire wr_opt4   = wr_access & hit_opt4;
	wire auto_inc  = opt2[AUTO_INC_BIT];
	wire bump      = access & auto_inc & (hit_opt2 | hit_opt3);

	// Check bit: hardware clear on exception wins over a software write of 1
	wire exc_take  = exception_event & !exception_is_addr_parity & !sel_s & chan_check;
	wire sw_chk_wr = wr_opt4;
	wire sw_chk_v  = setup_wdata[CHAN_CHECK_BIT];
	wire status_ok = !status_ind & !chan_check;

	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		unique case (setup_addr)
			REG_ID_LOW:   next_rdata = adapter_ready ? ADAPTER_ID[7:0] : ID_NOT_READY[7:0];
			REG_ID_HIGH:  next_rdata = adapter_ready ? ADAPTER_ID[15:8] : ID_NOT_READY[15:8];
			REG_OPT1:     next_rdata = opt1;
			REG_OPT2:     next_rdata = ext_sel ? ext_mem[ext_addr] : opt2;
			REG_OPT3:     next_rdata = ext_sel ? ext_mem[ext_addr] : opt3;
			REG_OPT4:     next_rdata = {chan_check, status_ind, opt4};
			REG_SUB_LOW:  next_rdata = status_ok ? check_status[7:0] : index[7:0];
			REG_SUB_HIGH: next_rdata = status_ok ? check_status[15:8] : index[15:8];
		endcase
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			opt1 <= OPT1_RESET;
			opt2 <= OPT2_RESET;
			opt3 <= OPT3_RESET;
			opt4 <= OPT4_RESET;
		end else begin
			if (wr_opt1) begin
				opt1 <= setup_wdata;
			end
			if (wr_opt2) begin
				opt2 <= setup_wdata;
			end
			if (wr_opt3) begin
				opt3 <= setup_wdata;
			end
			if (wr_opt4) begin
				opt4 <= setup_wdata[5:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			chan_check <= 1'b1;
			status_ind <= 1'b1;
		end else if (exc_take) begin
			chan_check <= 1'b0;
			status_ind <= 1'b0;
		end else if (sw_chk_wr) begin
			chan_check <= sw_chk_v;
			if (sw_chk_v) begin
				status_ind <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			index <= INDEX_RESET;
		end else if (wr_access & hit_sub_l) begin
			index <= {index[15:8], setup_wdata};
		end else if (wr_access & hit_sub_h) begin
			index <= {setup_wdata, index[7:0]};
		end else if (bump) begin
			index <= index + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (ext_wr) begin
			ext_mem[ext_addr] <= setup_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (clear_all) begin
			setup_rdata                <= 8'h00;
			setup_drive_en             <= 1'b0;
			channel_exception_line     <= 1'b0;
			exception_sync_mode        <= 1'b0;
			interface_enable           <= 1'b0;
			data_parity_enable_line    <= 1'b0;
			address_parity_enable_line <= 1'b0;
			data_parity_check_en       <= 1'b0;
			address_parity_check_en    <= 1'b0;
			io_select                  <= 3'h0;
			rom_select                 <= 4'h0;
			rom_base                   <= 20'hc0000;
			arb_level                  <= 4'h0;
			io_assign                  <= 6'h3f;
			ext_index                  <= INDEX_RESET;
		end else begin
			if (access & !wr_s) begin
				setup_rdata <= next_rdata;
			end
			setup_drive_en <= sel_s & !wr_s;
			if (exc_take) begin
				channel_exception_line <= 1'b1;
			end else if (sw_chk_wr & sw_chk_v) begin
				channel_exception_line <= 1'b0;
			end
			exception_sync_mode        <= opt2[SYNC_EXC_BIT] & exception_is_sync_class;
			interface_enable           <= opt1[CARD_ENABLE_BIT] & !sel_s;
			data_parity_enable_line    <= opt2[DATA_PAR_BIT] & opt1[CARD_ENABLE_BIT];
			address_parity_enable_line <= opt2[ADDR_PAR_BIT] & opt1[CARD_ENABLE_BIT];
			data_parity_check_en       <= opt2[DATA_PAR_BIT];
			address_parity_check_en    <= opt2[ADDR_PAR_BIT];
			io_select                  <= opt1[IO_SEL_LSB +: 3];
			rom_select                 <= opt1[ROM_SEL_LSB +: 4];
			rom_base                   <= {3'h6, opt1[ROM_SEL_LSB +: 4], 13'h0000};
			arb_level                  <= opt2[ARB_LEVEL_LSB +: 4];
			io_assign                  <= opt3[IO_ASSIGN_LSB +: 6];
			ext_index                  <= index;
		end
	end
endmodule

/* asc_pkg.sv */
package asc_pkg;
	localparam logic [2:0] REG_ID_LOW    = 3'h0;
	localparam logic [2:0] REG_ID_HIGH   = 3'h1;
	localparam logic [2:0] REG_OPT1      = 3'h2;
	localparam logic [2:0] REG_OPT2      = 3'h3;
	localparam logic [2:0] REG_OPT3      = 3'h4;
	localparam logic [2:0] REG_OPT4      = 3'h5;
	localparam logic [2:0] REG_SUB_LOW   = 3'h6;
	localparam logic [2:0] REG_SUB_HIGH  = 3'h7;
	// Option byte 1 (register 2)
	localparam int CARD_ENABLE_BIT   = 0;
	localparam int IO_SEL_LSB        = 1;
	localparam int ROM_SEL_LSB       = 4;
	// Option byte 2 (register 3)
	localparam int ARB_LEVEL_LSB     = 0;
	localparam int AUTO_INC_BIT      = 4;
	localparam int SYNC_EXC_BIT      = 5;
	localparam int DATA_PAR_BIT      = 6;
	localparam int ADDR_PAR_BIT      = 7;
	// Option byte 3 (register 4)
	localparam int IO_ASSIGN_LSB     = 0;
	// Option byte 4 (register 5)
	localparam int STATUS_IND_BIT    = 6;
	localparam int CHAN_CHECK_BIT    = 7;
	localparam logic [7:0]  OPT1_RESET   = 8'h00;
	localparam logic [7:0]  OPT2_RESET   = 8'h00;
	localparam logic [7:0]  OPT3_RESET   = 8'h3f;
	localparam logic [5:0]  OPT4_RESET   = 6'h00;
	localparam logic [15:0] INDEX_RESET  = 16'h0000;
	localparam logic [15:0] ID_NOT_READY = 16'h0000;
endpackage

/* asc_sync.sv */
module asc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage;
	if (WIDTH < 1) begin : g_width_bad
		$error("WIDTH must be positive");
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stage <= '0;
			q     <= '0;
		end else begin
			stage <= d;
			q     <= stage;
		end
	end
endmodule

/* asc_strobe.sv */
module asc_strobe (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic level,
	output logic      rise
);
	logic last;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			last <= 1'b0;
			rise <= 1'b0;
		end else begin
			last <= level;
			rise <= level & ~last;
		end
	end
endmodule

/* asc_config_asserts.sv */
module asc_config_asserts (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        channel_reset_line,
	input wire logic        card_setup_select,
	input wire logic        exception_event,
	input wire logic        exception_is_addr_parity,
	input wire logic        setup_drive_en,
	input wire logic        channel_exception_line,
	input wire logic        interface_enable,
	input wire logic        data_parity_enable_line,
	input wire logic        data_parity_check_en,
	input wire logic [3:0]  rom_select,
	input wire logic [19:0] rom_base,
	input wire logic [3:0]  arb_level,
	input wire logic [5:0]  io_assign
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	rst_value_a: assert property ($rose(resetn) |-> rom_base == 20'hc0000
		&& io_assign == 6'h3f && !interface_enable) else $error("bad reset value");
	rom_base_a: assert property (rom_base == {3'b110, rom_select, 13'h0000})
		else $error("rom base mismatch");
	par_pair_a: assert property (!data_parity_check_en |-> !data_parity_enable_line)
		else $error("parity line without enable");
	exc_cause_a: assert property ($rose(channel_exception_line) |-> $past(exception_event)
		&& !$past(exception_is_addr_parity)) else $error("exception without cause");
	exc_setup_a: assert property (card_setup_select [*6] |-> !$rose(channel_exception_line))
		else $error("exception during setup");
	iface_off_a: assert property (card_setup_select [*6] |-> !interface_enable)
		else $error("interface on during setup");
	drive_sel_a: assert property ((!card_setup_select) [*6] |-> !setup_drive_en)
		else $error("drive without select");
	cfg_hold_a: assert property ((!card_setup_select && !channel_reset_line) [*8]
		|-> $stable({rom_select, arb_level, io_assign})) else $error("field changed");
	cover property ($rose(channel_exception_line));
	cover property ($fell(channel_exception_line));
	cover property ($rose(setup_drive_en));
endmodule

bind asc_config asc_config_asserts u_asc_config_asserts (.clk, .resetn, .channel_reset_line,
	.card_setup_select, .exception_event, .exception_is_addr_parity, .setup_drive_en,
	.channel_exception_line, .interface_enable, .data_parity_enable_line, .data_parity_check_en,
	.rom_select, .rom_base, .arb_level, .io_assign);

/* asc_master.sv */
module asc_master (
	input wire logic       clk,
	output logic           card_setup_select,
	output logic           setup_write,
	output logic           setup_strobe,
	output logic [2:0]     setup_addr,
	output logic [7:0]     setup_wdata,
	input wire logic [7:0] setup_rdata,
	output logic           rd_valid,
	output logic [7:0]     rd_val
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{card_setup_select, setup_write, setup_strobe, rd_valid} = 4'h0;
		setup_addr = 3'h0;
		setup_wdata = 8'h00;
		rd_val = 8'h00;
	end
	// One setup cycle, select held around the strobe
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		#2;
		card_setup_select = 1'b1;
		setup_write = w;
		setup_addr = a;
		setup_wdata = d;
		repeat (3) @(posedge clk);
		#2 setup_strobe = 1'b1;
		repeat (6) @(posedge clk);
		#2;
		rd_valid = !w;
		rd_val = setup_rdata;
		setup_strobe = 1'b0;
		@(posedge clk);
		#2;
		rd_valid = 1'b0;
		card_setup_select = 1'b0;
		setup_addr = ~a;
		setup_wdata = ~d;
		repeat (5) @(posedge clk);
		#2;
	endtask
endmodule

/* adapter_setup_config_fields_bench.sv */
module adapter_setup_config_fields_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import asc_pkg::*;
	localparam logic [15:0] ID_VAL = 16'h6b4d; // Arbitrary value
	logic clk, resetn, channel_reset_line, adapter_ready, exception_event, exception_is_addr_parity;
	logic exception_is_sync_class, exception_sync_mode, data_parity_check_en, address_parity_check_en;
	logic ce;
	logic card_setup_select, setup_write, setup_strobe, setup_drive_en, rd_valid, interface_enable;
	logic channel_exception_line, data_parity_enable_line, address_parity_enable_line;
	logic [2:0]  setup_addr, io_select;
	logic [3:0]  rom_select, arb_level;
	logic [5:0]  io_assign;
	logic [7:0]  setup_wdata, setup_rdata, rd_val, d;
	logic [15:0] check_status, ext_index;
	logic [19:0] rom_base;
	logic [7:0]  exp_q[$];
	int          n_fail, n_tests;
	asc_config #(.ADAPTER_ID(ID_VAL)) u_asc_config (.clk, .resetn, .channel_reset_line,
		.card_setup_select, .setup_write, .setup_strobe, .setup_addr, .setup_wdata, .setup_rdata,
		.setup_drive_en, .adapter_ready, .exception_event, .exception_is_addr_parity,
		.exception_is_sync_class, .check_status, .channel_exception_line, .exception_sync_mode,
		.interface_enable, .data_parity_enable_line, .address_parity_enable_line,
		.data_parity_check_en, .address_parity_check_en, .io_select, .rom_select, .rom_base,
		.arb_level, .io_assign, .ext_index);
	asc_master u_asc_master (.clk, .card_setup_select, .setup_write, .setup_strobe, .setup_addr,
		.setup_wdata, .setup_rdata, .rd_valid, .rd_val);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_asc_master.acc(1'b0, a, 8'h00);
	endtask
	task automatic complete_run;
		$display("Compared %0d, failed %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) if (rd_valid === 1'b1) check(rd_val, exp_q.pop_front());
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#(40 * 3000);
		n_fail++;
		complete_run();
	end
	initial begin
		{resetn, channel_reset_line, adapter_ready, exception_event, exception_is_addr_parity,
			exception_is_sync_class} = 6'h0;
		check_status = 16'h0000;
		void'($urandom(32'ha20a));
		repeat (6) @(posedge clk);
		#2 resetn = 1'b1;
		rd(REG_ID_LOW, 8'h00);
		rd(REG_OPT1, 8'h00);
		rd(REG_OPT3, 8'h3f);
		rd(REG_OPT4, 8'hc0);
		adapter_ready = 1'b1;
		u_asc_master.acc(1'b1, REG_ID_LOW, 8'hff);
		rd(REG_ID_LOW, ID_VAL[7:0]);
		d = rd_val;
		rd(REG_ID_HIGH, ID_VAL[15:8]);
		check({7'h0, {rd_val, d} != 16'hffff}, 8'h01);
		$display("Identifier test done");
		repeat (3) begin
			d = $urandom;
			u_asc_master.acc(1'b1, REG_OPT1, d);
			rd(REG_OPT1, d);
			check({interface_enable, io_select, rom_select}, {d[0], d[3:1], d[7:4]});
			check(rom_base[19:12], {3'h6, d[7:4], 1'b0});
			ce = d[0];
			d = $urandom & 8'hcf;
			u_asc_master.acc(1'b1, REG_OPT2, d);
			check({address_parity_enable_line, data_parity_enable_line, arb_level},
				{2'h0, d[7:6] & {2{ce}}, d[3:0]});
			check({6'h0, address_parity_check_en, data_parity_check_en}, {6'h0, d[7:6]});
			d = $urandom & 8'h3f;
			u_asc_master.acc(1'b1, REG_OPT3, d);
			check({2'h0, io_assign}, d);
		end
		$display("Option field test done");
		for (int p = 1; p >= 0; p--) begin
			check_status = $urandom;
			exception_is_addr_parity = p[0];
			exception_event = 1'b1;
			@(posedge clk);
			#2 exception_event = 1'b0;
			repeat (2) @(posedge clk);
			#2 check({7'h0, channel_exception_line}, {7'h0, !p[0]});
			rd(REG_OPT4, p[0] ? 8'hc0 : 8'h00);
		end
		rd(REG_SUB_LOW, check_status[7:0]);
		rd(REG_SUB_HIGH, check_status[15:8]);
		u_asc_master.acc(1'b1, REG_OPT4, 8'h80);
		check({7'h0, channel_exception_line}, 8'h00);
		rd(REG_OPT4, 8'hc0);
		u_asc_master.acc(1'b1, REG_OPT4, 8'h00);
		exception_event = 1'b1;
		@(posedge clk);
		#2 exception_event = 1'b0;
		repeat (2) @(posedge clk);
		#2 check({7'h0, channel_exception_line}, 8'h00);
		rd(REG_OPT4, 8'h40);
		u_asc_master.acc(1'b1, REG_OPT4, 8'h80);
		$display("Exception test done");
		u_asc_master.acc(1'b1, REG_OPT2, 8'h10);
		rd(REG_OPT2, 8'h10);
		rd(REG_SUB_LOW, 8'h01);
		check(ext_index[7:0], 8'h01);
		d = $urandom;
		u_asc_master.acc(1'b1, REG_OPT3, d);
		u_asc_master.acc(1'b1, REG_SUB_LOW, 8'h01);
		rd(REG_OPT3, d);
		rd(REG_SUB_LOW, 8'h02);
		u_asc_master.acc(1'b1, REG_SUB_LOW, 8'h00);
		u_asc_master.acc(1'b1, REG_OPT2, 8'h20);
		exception_is_sync_class = 1'b1;
		repeat (2) @(posedge clk);
		#2 check({7'h0, exception_sync_mode}, 8'h01);
		channel_reset_line = 1'b1;
		repeat (4) @(posedge clk);
		#2 channel_reset_line = 1'b0;
		rd(REG_OPT2, 8'h00);
		rd(REG_SUB_LOW, 8'h00);
		check({7'h0, exception_sync_mode}, 8'h00);
		$display("Reset test done");
		complete_run();
	end
endmodule
